// ===== verilog/com_pkg.sv
// Constants, types and helpers for the channel one map register block
package com_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0]  MAP_INDEX       = 8'h11;
	localparam logic [7:0]  OTHER_EN_INDEX  = 8'h20;
	localparam logic [7:0]  STATUS_INDEX    = 8'h21;
	localparam logic [7:0]  MAP_ADDR        = {MAP_INDEX[5:0], 2'h0};
	localparam logic [7:0]  OTHER_EN_ADDR   = {OTHER_EN_INDEX[5:0], 2'h0};
	localparam logic [7:0]  STATUS_ADDR     = {STATUS_INDEX[5:0], 2'h0};

	// Channel map layout
	localparam int          MAP_W           = 16;
	localparam logic [15:0] MAP_RESET       = 16'h0001;
	localparam logic [15:0] MAP_WRITE_MASK  = 16'hb3ff;
	localparam int          ENABLE_BIT      = 15;
	localparam int          SETUP_LSB       = 12;
	localparam int          SETUP_MSB       = 13;
	localparam int          POS_LSB         = 5;
	localparam int          POS_MSB         = 9;
	localparam int          NEG_LSB         = 0;
	localparam int          NEG_MSB         = 4;

	// Input select codes and route vector positions
	localparam logic [4:0]  CODE_AIN_LAST   = 5'h04;
	localparam logic [4:0]  CODE_REF_POS    = 5'h15;
	localparam logic [4:0]  CODE_REF_NEG    = 5'h16;
	localparam int          ROUTE_W         = 7;
	localparam int          ROUTE_REF_POS   = 5;
	localparam int          ROUTE_REF_NEG   = 6;

	// Sequencer
	localparam int          NUM_CH          = 4;
	localparam logic [1:0]  CH_ONE          = 2'h1;
	localparam int          DWELL_CYCLES    = 16;
	localparam int          STATUS_BUSY_BIT = 8;

	// AXI responses
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

	typedef enum logic [1:0] {
		COM_SEL_NONE,
		COM_SEL_MAP,
		COM_SEL_OTHER,
		COM_SEL_STATUS
	} com_reg_sel_t;

	function automatic com_reg_sel_t com_decode(input logic [7:0] addr);
		com_reg_sel_t sel;
		sel = COM_SEL_NONE;
		if (addr == MAP_ADDR)
			sel = COM_SEL_MAP;
		else if (addr == OTHER_EN_ADDR)
			sel = COM_SEL_OTHER;
		else if (addr == STATUS_ADDR)
			sel = COM_SEL_STATUS;
		return sel;
	endfunction : com_decode

	// Unlisted codes route nothing, so an undefined code never shorts two inputs
	function automatic logic [ROUTE_W-1:0] com_route(input logic [4:0] code);
		logic [ROUTE_W-1:0] hot;
		hot = '0;
		if (code <= CODE_AIN_LAST)
			hot[code[2:0]] = 1'b1;
		else if (code == CODE_REF_POS)
			hot[ROUTE_REF_POS] = 1'b1;
		else if (code == CODE_REF_NEG)
			hot[ROUTE_REF_NEG] = 1'b1;
		return hot;
	endfunction : com_route

endpackage : com_pkg

// ===== verilog/com_sequencer.sv
// Round-robin sequencer over the enabled channels
`timescale 1ns/100ps
module com_sequencer
	import com_pkg::*;
#(
	parameter int N_CH  = NUM_CH,
	parameter int DWELL = DWELL_CYCLES
) (
	input  wire logic            clk_sys_in,
	input  wire logic            srst_in,
	input  wire logic [N_CH-1:0] enable_in,
	output logic      [1:0]      active_out,
	output logic                 busy_out
);

	logic [15:0] dwell_count;
	logic [1:0]  next_channel;
	logic        current_on;
	logic        dwell_done;

	assign current_on = enable_in[active_out];
	assign dwell_done = (dwell_count == 16'(DWELL - 1));

	// First enabled channel after the current one, wrapping around
	always_comb begin
		next_channel = active_out;
		for (int k = N_CH; k >= 1; k--) begin
			if (enable_in[2'(int'(active_out) + k)])
				next_channel = 2'(int'(active_out) + k);
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			active_out  <= 2'h0;
			busy_out    <= 1'b0;
			dwell_count <= 16'h0000;
		end else begin
			busy_out <= |enable_in;
			if (!current_on || dwell_done) begin
				active_out  <= next_channel;
				dwell_count <= 16'h0000;
			end else begin
				dwell_count <= dwell_count + 16'h0001;
			end
		end
	end

endmodule : com_sequencer

// ===== verilog/com_map_regs.sv
// Channel one map register with AXI4-Lite slave and channel sequencing
//
// Overview of operation
// - Map register at index 0x11, reset 0x0001.
// - Bit 15 enables channel one, reset off.
// - Several enabled channels are sequenced automatically.
// - Bit 14 reserved, reads zero, software writes zero.
// - Bits 13:12 choose setup zero to three.
// - Chosen setup applies its four configuration registers.
// - Bits 11:10 reserved, read zero, write zeros.
// - Bits 9:5 route positive input, reset input zero.
// - Bits 4:0 route negative input, reset input one.
`timescale 1ns/100ps
module com_map_regs
	import com_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int DWELL  = DWELL_CYCLES
) (
	input  wire logic              clk_sys_in,
	input  wire logic              srst_in,
	// AXI4-Lite write address
	input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
	input  wire logic [2:0]        s_axi_awprot_in,
	input  wire logic              s_axi_awvalid_in,
	output logic                   s_axi_awready_out,
	// AXI4-Lite write data
	input  wire logic [31:0]       s_axi_wdata_in,
	input  wire logic [3:0]        s_axi_wstrb_in,
	input  wire logic              s_axi_wvalid_in,
	output logic                   s_axi_wready_out,
	// AXI4-Lite write response
	output logic      [1:0]        s_axi_bresp_out,
	output logic                   s_axi_bvalid_out,
	input  wire logic              s_axi_bready_in,
	// AXI4-Lite read address
	input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
	input  wire logic [2:0]        s_axi_arprot_in,
	input  wire logic              s_axi_arvalid_in,
	output logic                   s_axi_arready_out,
	// AXI4-Lite read data
	output logic      [31:0]       s_axi_rdata_out,
	output logic      [1:0]        s_axi_rresp_out,
	output logic                   s_axi_rvalid_out,
	input  wire logic              s_axi_rready_in,
	// Channel one configuration towards the converter
	output logic                   channel_one_enable_out,
	output logic      [1:0]        channel_one_setup_select_out,
	output logic      [3:0]        channel_one_setup_apply_out,
	output logic      [ROUTE_W-1:0] channel_one_positive_input_out,
	output logic      [ROUTE_W-1:0] channel_one_negative_input_out,
	output logic                   channel_one_selected_out,
	// Sequencer state
	output logic      [1:0]        active_channel_out,
	output logic                   sequencing_out
);

	// Register storage
	logic [MAP_W-1:0]  channel_one_map;
	logic [NUM_CH-1:0] other_enable;

	// Write channel state
	logic              aw_got;
	logic              w_got;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0]       w_data;
	logic [3:0]        w_strb;

	// Handshakes
	wire               aw_hs;
	wire               w_hs;
	wire               b_hs;
	wire               ar_hs;
	wire               r_hs;
	wire               write_fire;
	wire               next_aw_got;
	wire               next_w_got;

	// Decoding
	wire com_reg_sel_t wr_sel;
	wire com_reg_sel_t rd_sel;
	wire               wr_hit;
	wire               rd_hit;
	wire [15:0]        byte_mask;
	wire [15:0]        map_lanes;
	wire [MAP_W-1:0]   next_channel_one_map;
	wire [NUM_CH-1:0]  next_other_enable;
	wire [NUM_CH-1:0]  all_enable;
	wire [31:0]        map_word;
	wire [31:0]        other_word;
	wire [31:0]        status_word;
	logic [31:0]       read_word;
	logic [31:0]       status_v;
	logic [NUM_CH-1:0] all_enable_v;
	wire [1:0]         next_bresp;
	wire [1:0]         next_rresp;

	// Field views of the map register
	wire               field_enable;
	wire [1:0]         field_setup;
	wire [4:0]         field_pos;
	wire [4:0]         field_neg;

	// Sequencer outputs
	wire [1:0]         seq_active;
	wire               seq_busy;

	// Next values of the converter-side view
	wire               next_enable_view;
	wire [1:0]         next_setup_view;
	wire [3:0]         next_apply_view;
	wire [ROUTE_W-1:0] next_pos_view;
	wire [ROUTE_W-1:0] next_neg_view;
	wire               next_selected_view;

	// Converter-view reset values follow the map reset word
	localparam logic [1:0] RESET_SETUP = MAP_RESET[SETUP_MSB:SETUP_LSB];
	localparam logic [3:0] RESET_APPLY = 4'(4'h1 << RESET_SETUP);

	assign aw_hs = s_axi_awvalid_in && s_axi_awready_out;
	assign w_hs  = s_axi_wvalid_in && s_axi_wready_out;
	assign b_hs  = s_axi_bvalid_out && s_axi_bready_in;
	assign ar_hs = s_axi_arvalid_in && s_axi_arready_out;
	assign r_hs  = s_axi_rvalid_out && s_axi_rready_in;

	// Address and data are held until the response is taken, so each may come first
	assign next_aw_got = (aw_got || aw_hs) && !b_hs;
	assign next_w_got  = (w_got || w_hs) && !b_hs;
	assign write_fire  = aw_got && w_got && !s_axi_bvalid_out;

	assign wr_sel = com_decode(8'(aw_addr));
	assign rd_sel = com_decode(8'(s_axi_araddr_in));
	assign wr_hit = (wr_sel != COM_SEL_NONE);
	assign rd_hit = (rd_sel != COM_SEL_NONE);

	// Unmapped addresses answer with an error rather than silently aliasing
	assign next_bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
	assign next_rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;

	// Only the two low byte lanes carry the 16-bit map
	assign byte_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
	assign map_lanes = byte_mask & MAP_WRITE_MASK;

	assign next_channel_one_map = (channel_one_map & ~map_lanes)
		| (w_data[MAP_W-1:0] & map_lanes);

	// Bit for channel one is a read-only mirror in the other-enable register
	assign next_other_enable = w_strb[0] ? w_data[NUM_CH-1:0] : other_enable;

	assign field_enable = channel_one_map[ENABLE_BIT];
	assign field_setup  = channel_one_map[SETUP_MSB:SETUP_LSB];
	assign field_pos    = channel_one_map[POS_MSB:POS_LSB];
	assign field_neg    = channel_one_map[NEG_MSB:NEG_LSB];

	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			all_enable_v[c] = other_enable[c];
		end
		all_enable_v[CH_ONE] = field_enable;
	end

	assign all_enable = all_enable_v;

	// Status is combinational, so a read sees the sequencer as it stands at the address handshake
	always_comb begin
		status_v                        = 32'h00000000;
		status_v[STATUS_BUSY_BIT]       = seq_busy;
		status_v[$bits(seq_active)-1:0] = seq_active;
	end

	assign map_word    = {16'h0000, channel_one_map & MAP_WRITE_MASK};
	assign other_word  = {{(32 - NUM_CH){1'b0}}, all_enable};
	assign status_word = status_v;

	always_comb begin
		case (rd_sel)
			COM_SEL_MAP: begin
				read_word = map_word;
			end
			COM_SEL_OTHER: begin
				read_word = other_word;
			end
			COM_SEL_STATUS: begin
				read_word = status_word;
			end
			default: begin
				read_word = 32'h00000000;
			end
		endcase
	end

	// Write address and data capture
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			aw_got            <= 1'b0;
			w_got             <= 1'b0;
			aw_addr           <= '0;
			w_data            <= 32'h00000000;
			w_strb            <= 4'h0;
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out  <= 1'b0;
		end else begin
			aw_got            <= next_aw_got;
			w_got             <= next_w_got;
			s_axi_awready_out <= !next_aw_got;
			s_axi_wready_out  <= !next_w_got;
			if (aw_hs) begin
				aw_addr <= s_axi_awaddr_in;
			end
			if (w_hs) begin
				w_data <= s_axi_wdata_in;
				w_strb <= s_axi_wstrb_in;
			end
		end
	end

	// Write response
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out  <= RESP_OKAY;
		end else if (write_fire) begin
			s_axi_bvalid_out <= 1'b1;
			s_axi_bresp_out  <= next_bresp;
		end else if (b_hs) begin
			s_axi_bvalid_out <= 1'b0;
		end
	end

	// Register updates
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			channel_one_map <= MAP_RESET;
			other_enable    <= '0;
		end else if (write_fire && wr_sel == COM_SEL_MAP) begin
			channel_one_map <= next_channel_one_map;
		end else if (write_fire && wr_sel == COM_SEL_OTHER) begin
			other_enable    <= next_other_enable;
		end
	end

	// Read path: data is captured at the address handshake
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b0;
			s_axi_rdata_out   <= 32'h00000000;
			s_axi_rresp_out   <= RESP_OKAY;
		end else if (ar_hs) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b1;
			s_axi_rdata_out   <= read_word;
			s_axi_rresp_out   <= next_rresp;
		end else if (r_hs || !s_axi_rvalid_out) begin
			s_axi_arready_out <= 1'b1;
			s_axi_rvalid_out  <= 1'b0;
		end
	end

	com_sequencer #(
		.N_CH  (NUM_CH),
		.DWELL (DWELL)
	) u_sequencer (
		.clk_sys_in (clk_sys_in),
		.srst_in    (srst_in),
		.enable_in  (all_enable),
		.active_out (seq_active),
		.busy_out   (seq_busy)
	);

	assign active_channel_out = seq_active;
	assign sequencing_out     = seq_busy;

	// Selected needs the sequencer running on channel one, not just the enable bit
	assign next_enable_view   = field_enable;
	assign next_setup_view    = field_setup;
	assign next_apply_view    = 4'(4'h1 << field_setup);
	assign next_pos_view      = com_route(field_pos);
	assign next_neg_view      = com_route(field_neg);
	assign next_selected_view = field_enable && seq_busy
		&& (seq_active == CH_ONE);

	// Converter-side view; one cycle behind the register, which the converter tolerates
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			channel_one_enable_out         <= MAP_RESET[ENABLE_BIT];
			channel_one_setup_select_out   <= RESET_SETUP;
			channel_one_setup_apply_out    <= RESET_APPLY;
			channel_one_positive_input_out <= com_route(MAP_RESET[POS_MSB:POS_LSB]);
			channel_one_negative_input_out <= com_route(MAP_RESET[NEG_MSB:NEG_LSB]);
			channel_one_selected_out       <= 1'b0;
		end else begin
			channel_one_enable_out         <= next_enable_view;
			channel_one_setup_select_out   <= next_setup_view;
			channel_one_setup_apply_out    <= next_apply_view;
			channel_one_positive_input_out <= next_pos_view;
			channel_one_negative_input_out <= next_neg_view;
			channel_one_selected_out       <= next_selected_view;
		end
	end

endmodule : com_map_regs

// ===== verilog/com_map_regs_fix.sv
// No logic here; the block is the map register module and its sequencer

// ===== tb/com_map_regs_props.sv
// Assertions on the ports of the channel one map register block
`timescale 1ns/100ps
module com_map_regs_props
	import com_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int DWELL  = DWELL_CYCLES
) (
	input wire logic               clk_sys_in,
	input wire logic               srst_in,
	input wire logic               s_axi_awvalid_in,
	input wire logic               s_axi_awready_out,
	input wire logic               s_axi_wvalid_in,
	input wire logic               s_axi_wready_out,
	input wire logic               s_axi_bvalid_out,
	input wire logic               s_axi_arvalid_in,
	input wire logic               s_axi_arready_out,
	input wire logic               s_axi_rvalid_out,
	input wire logic [31:0]        s_axi_rdata_out,
	input wire logic               channel_one_enable_out,
	input wire logic [1:0]         channel_one_setup_select_out,
	input wire logic [3:0]         channel_one_setup_apply_out,
	input wire logic [ROUTE_W-1:0] channel_one_positive_input_out,
	input wire logic [ROUTE_W-1:0] channel_one_negative_input_out,
	input wire logic               channel_one_selected_out,
	input wire logic               sequencing_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);
	sequence s_wr_hs;
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
	endsequence
	sequence s_rd_hs;
		s_axi_arvalid_in && s_axi_arready_out;
	endsequence
	property p_wr_resp; s_wr_hs |-> ##[1:2] s_axi_bvalid_out; endproperty
	property p_rd_resp; s_rd_hs |=> s_axi_rvalid_out; endproperty
	property p_rsv; s_axi_rvalid_out |-> !s_axi_rdata_out[14] && s_axi_rdata_out[11:10] == 2'h0;
	endproperty
	property p_reset;
		$fell(srst_in) |-> !channel_one_enable_out && channel_one_setup_select_out == 2'h0
			&& channel_one_positive_input_out == 7'h01 && channel_one_negative_input_out == 7'h02;
	endproperty
	property p_apply;
		channel_one_setup_apply_out == 4'h1 << channel_one_setup_select_out;
	endproperty
	// Fields only move on a completed write
	property p_setup_hold;
		$changed(channel_one_setup_select_out) |-> $past(s_axi_bvalid_out);
	endproperty
	property p_pos_hold;
		$changed(channel_one_positive_input_out) |-> $past(s_axi_bvalid_out);
	endproperty
	property p_neg_hold;
		$changed(channel_one_negative_input_out) |-> $past(s_axi_bvalid_out);
	endproperty
	property p_seq; channel_one_enable_out [*2] |-> sequencing_out; endproperty
	property p_sel_off; !channel_one_enable_out [*2] |-> !channel_one_selected_out; endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
	a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
	a_rsv: assert property (p_rsv) else $error("reserved bit set");
	a_reset: assert property (p_reset) else $error("bad reset state");
	a_apply: assert property (p_apply) else $error("setup apply wrong");
	a_setup_hold: assert property (p_setup_hold) else $error("setup moved");
	a_pos_hold: assert property (p_pos_hold) else $error("pos moved");
	a_neg_hold: assert property (p_neg_hold) else $error("neg moved");
	a_seq: assert property (p_seq) else $error("not sequencing");
	a_sel_off: assert property (p_sel_off) else $error("disabled but selected");
endmodule : com_map_regs_props

bind com_map_regs com_map_regs_props #(.ADDR_W(ADDR_W), .DWELL(DWELL)) u_props (.*);

// ===== tb/tb_com_map_regs.sv
// Self-checking bench for the channel one map register block
`timescale 1ns/100ps
module tb_com_map_regs;
	import com_pkg::*;
	logic        clk = 1'h0, rst = 1'h1, awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
	logic [7:0]  awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rd;
	logic [3:0]  ws = 4'hf;
	logic        awr, wr, bv, arr, rv, en, sel, sq;
	logic [1:0]  bresp, rresp, ss, act;
	logic [3:0]  app;
	logic [6:0]  pos, neg;
	int          n_errors = 0, samples_checked = 0, cyc = 0;
	// Short dwell keeps the sequencing scenario brief
	com_map_regs #(.ADDR_W(8), .DWELL(2)) dut (.clk_sys_in(clk), .srst_in(rst),
		.s_axi_awaddr_in(awa), .s_axi_awprot_in(3'h0), .s_axi_awvalid_in(awv),
		.s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws),
		.s_axi_wvalid_in(wv), .s_axi_wready_out(wr), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bv), .s_axi_bready_in(br), .s_axi_araddr_in(ara),
		.s_axi_arprot_in(3'h0), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
		.s_axi_rdata_out(rd), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
		.s_axi_rready_in(rr), .channel_one_enable_out(en), .channel_one_setup_select_out(ss),
		.channel_one_setup_apply_out(app), .channel_one_positive_input_out(pos),
		.channel_one_negative_input_out(neg), .channel_one_selected_out(sel),
		.active_channel_out(act), .sequencing_out(sq));
	initial forever #2 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			summarize();
		end
	end
	task summarize();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize
	task check(string nm, logic [31:0] s, logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask : check
	task wrt(logic [7:0] a, logic [31:0] d, logic [1:0] er);
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		br <= 1'h1;
		do begin
			@(posedge clk);
			if (awr) awv <= 1'h0;
			if (wr) wv <= 1'h0;
		end while (!bv);
		check("bresp", {30'h0, bresp}, {30'h0, er});
		br <= 1'h0;
		// Converter view settles one edge after the write
		@(posedge clk);
	endtask : wrt
	task rdc(logic [7:0] a, logic [31:0] m, logic [31:0] e, logic [1:0] er);
		@(posedge clk);
		ara <= a;
		arv <= 1'h1;
		rr <= 1'h1;
		do begin
			@(posedge clk);
			if (arr) arv <= 1'h0;
		end while (!rv);
		check("rdata", rd & m, e);
		check("rresp", {30'h0, rresp}, {30'h0, er});
		rr <= 1'h0;
	endtask : rdc
	task t_reset();
		rdc(MAP_ADDR, 32'hffffffff, 32'h1, RESP_OKAY);
		check("en", {31'h0, en}, 32'h0);
		check("pos", {25'h0, pos}, 32'h1);
		check("neg", {25'h0, neg}, 32'h2);
		check("apply", {28'h0, app}, 32'h1);
	endtask : t_reset
	task t_fields();
		wrt(MAP_ADDR, 32'h0000b3ff, RESP_OKAY);
		rdc(MAP_ADDR, 32'hffffffff, 32'hb3ff, RESP_OKAY);
		check("en", {31'h0, en}, 32'h1);
		check("apply", {28'h0, app}, 32'h8);
		// Lane 0 alone must leave the upper byte of the map untouched
		ws <= 4'h1;
		wrt(MAP_ADDR, 32'h00000000, RESP_OKAY);
		rdc(MAP_ADDR, 32'hffffffff, 32'hb300, RESP_OKAY);
		ws <= 4'hf;
	endtask : t_fields
	task t_routes();
		for (int i = 0; i < 5; i++) begin
			wrt(MAP_ADDR, 32'((i % 4) << 12 | i << 5 | (4 - i)), RESP_OKAY);
			check("setup", {30'h0, ss}, 32'(i % 4));
			check("apply", {28'h0, app}, 32'(1 << (i % 4)));
			check("pos", {25'h0, pos}, 32'(1 << i));
			check("neg", {25'h0, neg}, 32'(1 << (4 - i)));
		end
		wrt(MAP_ADDR, 32'h000002b6, RESP_OKAY);
		check("pos ref", {25'h0, pos}, 32'h20);
		check("neg ref", {25'h0, neg}, 32'h40);
	endtask : t_routes
	task t_seq();
		int n0, n1;
		n0 = 0;
		n1 = 0;
		wrt(OTHER_EN_ADDR, 32'h1, RESP_OKAY);
		wrt(MAP_ADDR, 32'h8000, RESP_OKAY);
		check("setup", {30'h0, ss}, 32'h0);
		rdc(OTHER_EN_ADDR, 32'hffffffff, 32'h3, RESP_OKAY);
		check("sq", {31'h0, sq}, 32'h1);
		rdc(STATUS_ADDR, 32'h100, 32'h100, RESP_OKAY);
		repeat (40) begin
			@(posedge clk);
			if (act === 2'h0) n0++;
			if (sel === 1'h1) n1++;
		end
		check("ch0 visits", 32'(n0 > 0), 32'h1);
		check("ch1 visits", 32'(n1 > 0), 32'h1);
		wrt(MAP_ADDR, 32'h0, RESP_OKAY);
		n1 = 0;
		repeat (20) begin
			@(posedge clk);
			if (sel !== 1'h0) n1++;
		end
		check("ch1 off", 32'(n1), 32'h0);
	endtask : t_seq
	task t_unmapped();
		wrt(8'h10, 32'hffff, RESP_SLVERR);
		rdc(8'h10, 32'hffffffff, 32'h0, RESP_SLVERR);
		rdc(MAP_ADDR, 32'hffffffff, 32'h0, RESP_OKAY);
	endtask : t_unmapped
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		t_reset();
		t_fields();
		t_routes();
		t_seq();
		t_unmapped();
		summarize();
	end
endmodule : tb_com_map_regs
